// ==== rtl/sensor_regs_pkg.sv ====
// Constants for the inductive sensor result register bank
package sensor_regs_pkg;

  // ----------------------------------------------------------------
  // Register addresses (7-bit serial address)
  // ----------------------------------------------------------------
  localparam logic [6:0] ADDR_THR_HI_HIGH = 7'h07;
  localparam logic [6:0] ADDR_THR_LO_LOW  = 7'h08;
  localparam logic [6:0] ADDR_THR_LO_HIGH = 7'h09;
  localparam logic [6:0] ADDR_INT_CFG     = 7'h0A;
  localparam logic [6:0] ADDR_PWR_CFG     = 7'h0B;
  localparam logic [6:0] ADDR_STATUS      = 7'h20;
  localparam logic [6:0] ADDR_PROX_LOW    = 7'h21;
  localparam logic [6:0] ADDR_PROX_HIGH   = 7'h22;
  localparam logic [6:0] ADDR_COUNT_LOW   = 7'h23;
  localparam logic [6:0] ADDR_COUNT_MID   = 7'h24;
  localparam logic [6:0] ADDR_COUNT_HIGH  = 7'h25;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_THR_HI_HIGH  = 8'hFF;
  localparam logic [7:0] RST_THR_LO       = 8'h00;
  localparam logic [7:0] RST_INT_CFG      = 8'h00;
  localparam logic [7:0] RST_PWR_CFG      = 8'h00;

  // ----------------------------------------------------------------
  // Interrupt pin function codes and field positions
  // ----------------------------------------------------------------
  localparam logic [2:0] PIN_FN_OFF       = 3'h0;
  localparam logic [2:0] PIN_FN_WAKE      = 3'h1;
  localparam logic [2:0] PIN_FN_COMPARE   = 3'h2;
  localparam logic [2:0] PIN_FN_READY     = 3'h4;
  localparam int         PWR_ACTIVE_BIT   = 0;
  localparam int         ST_OSC_BIT       = 7;
  localparam int         ST_READY_BIT     = 6;
  localparam int         ST_WAKE_BIT      = 5;
  localparam int         ST_COMP_BIT      = 4;

  // ----------------------------------------------------------------
  // Serial frame: R/W bit, 7 address bits, 8 data bits
  // ----------------------------------------------------------------
  localparam logic [4:0] CMD_LAST_BIT     = 5'h07;
  localparam logic [4:0] FRAME_LAST_BIT   = 5'h0F;
  localparam logic [4:0] DATA_FIRST_BIT   = 5'h08;
  // Pin sync order: 0 clock, 1 select, 2 data in, 3 sensor
  localparam logic [3:0] PIN_IDLE         = 4'h2;

  // ----------------------------------------------------------------
  // Conversion window and watchdog
  // ----------------------------------------------------------------
  // Window of 64 periods gives f / 64 = one result per 64 periods
  localparam logic [11:0] WIN_BASE_PERIODS = 12'h040;
  localparam logic [2:0]  WIN_BASE_CODE    = 3'h2;
  localparam logic [8:0]  WDOG_SPAN        = 9'h100;
  localparam int          WDOG_SHIFT       = 6;

endpackage

// ==== rtl/inductive_sensor_result_regs.sv ====
// Result and comparator register bank with serial register port
`timescale 1ns/1ps
module inductive_sensor_result_regs
  import sensor_regs_pkg::*;
(
  input  wire logic        clock_i,
  input  wire logic        rst_b_i,
  input  wire logic        spi_clk_i,
  input  wire logic        spi_cs_b_i,
  input  wire logic        spi_mosi_i,
  input  wire logic        sensor_osc_i,
  input  wire logic [7:0]  upper_threshold_low_byte_i,
  input  wire logic [2:0]  conversion_window_length_i,
  input  wire logic [7:0]  min_sensor_freq_i,
  input  wire logic [15:0] proximity_sample_i,
  output logic             spi_miso_o,
  output logic             spi_miso_oe_b_o,
  output logic             interrupt_output_pin_b_o,
  output logic             conversion_enable_o,
  output logic             result_available_signal_o
);

  // ----------------------------------------------------------------
  // Pin synchronisers and glitch filter
  // ----------------------------------------------------------------
  logic [3:0]  pin_raw;
  logic [3:0]  sync1_q;
  logic [3:0]  sync2_q;
  logic [3:0]  sync3_q;
  logic [3:0]  pin_q;
  logic [3:0]  pin_prev_q;
  logic [3:0]  pin_agree;
  logic [3:0]  pin_d;

  assign pin_raw   = {sensor_osc_i, spi_mosi_i, spi_cs_b_i, spi_clk_i};
  assign pin_agree = ~(sync2_q ^ sync3_q);
  assign pin_d     = (pin_agree & sync3_q) | (~pin_agree & pin_q);

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sync1_q    <= PIN_IDLE;
      sync2_q    <= PIN_IDLE;
      sync3_q    <= PIN_IDLE;
      pin_q      <= PIN_IDLE;
      pin_prev_q <= PIN_IDLE;
    end else begin
      sync1_q    <= pin_raw;
      sync2_q    <= sync1_q;
      sync3_q    <= sync2_q;
      pin_q      <= pin_d;
      pin_prev_q <= pin_q;
    end
  end

  logic sclk_rise;
  logic sclk_fall;
  logic cs_active;
  logic mosi_bit;
  logic sensor_rise;

  assign sclk_rise   = pin_q[0] & ~pin_prev_q[0];
  assign sclk_fall   = ~pin_q[0] & pin_prev_q[0];
  assign cs_active   = ~pin_q[1];
  assign mosi_bit    = pin_q[2];
  assign sensor_rise = pin_q[3] & ~pin_prev_q[3];

  // ----------------------------------------------------------------
  // Serial frame decode
  // ----------------------------------------------------------------
  logic [4:0]  bit_cnt_q;
  logic [6:0]  shift_in_q;
  logic        frame_read_q;
  logic [6:0]  frame_addr_q;
  logic [7:0]  shift_out_q;
  logic [7:0]  rx_byte;
  logic        cmd_done;
  logic        cmd_read;
  logic [6:0]  cmd_addr;
  logic        write_done;

  assign rx_byte    = {shift_in_q, mosi_bit};
  assign cmd_done   = cs_active & sclk_rise & (bit_cnt_q == CMD_LAST_BIT);
  assign cmd_read   = rx_byte[7];
  assign cmd_addr   = rx_byte[6:0];
  assign write_done = cs_active & sclk_rise & ~frame_read_q
                      & (bit_cnt_q == FRAME_LAST_BIT);

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  logic [7:0]  thr_hi_high_q;
  logic [7:0]  thr_lo_low_q;
  logic [7:0]  thr_lo_high_q;
  logic [7:0]  int_cfg_q;
  logic [7:0]  pwr_cfg_q;
  logic [15:0] thr_hi;
  logic [15:0] thr_lo;
  logic [2:0]  pin_fn;
  logic        active;

  assign thr_hi = {thr_hi_high_q, upper_threshold_low_byte_i};
  assign thr_lo = {thr_lo_high_q, thr_lo_low_q};
  assign pin_fn = int_cfg_q[2:0];
  assign active = pwr_cfg_q[PWR_ACTIVE_BIT];

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      thr_hi_high_q <= RST_THR_HI_HIGH;
      thr_lo_low_q  <= RST_THR_LO;
      thr_lo_high_q <= RST_THR_LO;
      int_cfg_q     <= RST_INT_CFG;
      pwr_cfg_q     <= RST_PWR_CFG;
    end else if (write_done) begin
      if (frame_addr_q == ADDR_THR_HI_HIGH) thr_hi_high_q <= rx_byte;
      if (frame_addr_q == ADDR_THR_LO_LOW)  thr_lo_low_q  <= rx_byte;
      if (frame_addr_q == ADDR_THR_LO_HIGH) thr_lo_high_q <= rx_byte;
      if (frame_addr_q == ADDR_INT_CFG)     int_cfg_q     <= rx_byte;
      if (frame_addr_q == ADDR_PWR_CFG)     pwr_cfg_q     <= rx_byte;
    end
  end

  // ----------------------------------------------------------------
  // Conversion window and period counter
  // ----------------------------------------------------------------
  logic [2:0]  win_shift;
  logic [11:0] win_periods;
  logic [11:0] sens_cnt_q;
  logic [23:0] tb_cnt_q;
  logic [23:0] tb_cnt_inc;
  logic [23:0] period_count_q;
  logic        conv_strobe;

  assign win_shift   = (conversion_window_length_i < WIN_BASE_CODE) ? 3'h0
                       : conversion_window_length_i - WIN_BASE_CODE;
  assign win_periods = WIN_BASE_PERIODS << win_shift;
  assign conv_strobe = active & sensor_rise
                       & (sens_cnt_q == win_periods - 12'h001);
  assign tb_cnt_inc  = (&tb_cnt_q) ? tb_cnt_q : tb_cnt_q + 24'h000001;

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sens_cnt_q     <= 12'h000;
      tb_cnt_q       <= 24'h000000;
      period_count_q <= 24'h000000;
    end else if (!active) begin
      sens_cnt_q <= 12'h000;
      tb_cnt_q   <= 24'h000000;
    end else if (conv_strobe) begin
      sens_cnt_q     <= 12'h000;
      tb_cnt_q       <= 24'h000000;
      period_count_q <= tb_cnt_inc;
    end else begin
      tb_cnt_q <= tb_cnt_inc;
      if (sensor_rise) sens_cnt_q <= sens_cnt_q + 12'h001;
    end
  end

  // ----------------------------------------------------------------
  // Result capture, comparator and flags
  // ----------------------------------------------------------------
  logic [15:0] latest_q;
  logic [15:0] prox_q;
  logic        comp_q;
  logic        above_q;
  logic        ready_q;
  logic        prox_read;

  assign prox_read = cmd_done & cmd_read & (cmd_addr == ADDR_PROX_LOW);

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      latest_q <= 16'h0000;
      prox_q   <= 16'h0000;
      comp_q   <= 1'b0;
      above_q  <= 1'b0;
      ready_q  <= 1'b0;
    end else begin
      if (conv_strobe) begin
        latest_q <= proximity_sample_i;
        above_q  <= proximity_sample_i > thr_hi;
        if (proximity_sample_i > thr_hi)
          comp_q <= 1'b1;
        else if (proximity_sample_i < thr_lo)
          comp_q <= 1'b0;
      end
      if (prox_read) prox_q <= latest_q;
      if (conv_strobe) ready_q <= 1'b1;
      else if (prox_read) ready_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Oscillation watchdog
  // ----------------------------------------------------------------
  logic [15:0] wd_cnt_q;
  logic [15:0] wd_limit;
  logic        osc_timeout_q;

  // Higher minimum-frequency setting gives a shorter allowance
  assign wd_limit = (16'(WDOG_SPAN) - {8'h00, min_sensor_freq_i})
                    << WDOG_SHIFT;

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wd_cnt_q      <= 16'h0000;
      osc_timeout_q <= 1'b0;
    end else if (!active || sensor_rise) begin
      wd_cnt_q      <= 16'h0000;
      osc_timeout_q <= 1'b0;
    end else if (wd_cnt_q >= wd_limit) begin
      osc_timeout_q <= 1'b1;
    end else begin
      wd_cnt_q <= wd_cnt_q + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // Read data and serial output
  // ----------------------------------------------------------------
  logic       wake_on;
  logic [7:0] status_byte;
  logic [7:0] rd_data;

  assign wake_on     = (pin_fn == PIN_FN_WAKE) & above_q;
  assign status_byte = {osc_timeout_q, ready_q, ~wake_on, comp_q,
                        4'h0};

  always_comb begin
    rd_data = 8'h00;
    unique case (cmd_addr)
      ADDR_THR_HI_HIGH: rd_data = thr_hi_high_q;
      ADDR_THR_LO_LOW:  rd_data = thr_lo_low_q;
      ADDR_THR_LO_HIGH: rd_data = thr_lo_high_q;
      ADDR_INT_CFG:     rd_data = int_cfg_q;
      ADDR_PWR_CFG:     rd_data = pwr_cfg_q;
      ADDR_STATUS:      rd_data = status_byte;
      ADDR_PROX_LOW:    rd_data = latest_q[7:0];
      ADDR_PROX_HIGH:   rd_data = prox_q[15:8];
      ADDR_COUNT_LOW:   rd_data = period_count_q[7:0];
      ADDR_COUNT_MID:   rd_data = period_count_q[15:8];
      ADDR_COUNT_HIGH:  rd_data = period_count_q[23:16];
      default:          rd_data = 8'h00;
    endcase
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      bit_cnt_q       <= 5'h00;
      shift_in_q      <= 7'h00;
      frame_read_q    <= 1'b0;
      frame_addr_q    <= 7'h00;
      shift_out_q     <= 8'h00;
      spi_miso_o      <= 1'b0;
      spi_miso_oe_b_o <= 1'b1;
    end else begin
      spi_miso_oe_b_o <= ~cs_active;
      if (!cs_active) begin
        bit_cnt_q <= 5'h00;
      end else if (sclk_rise) begin
        shift_in_q <= rx_byte[6:0];
        if (bit_cnt_q <= FRAME_LAST_BIT) bit_cnt_q <= bit_cnt_q + 5'h01;
        if (cmd_done) begin
          frame_read_q <= cmd_read;
          frame_addr_q <= cmd_addr;
          shift_out_q  <= cmd_read ? rd_data : 8'h00;
        end
      end else if (sclk_fall && bit_cnt_q >= DATA_FIRST_BIT) begin
        spi_miso_o  <= shift_out_q[7];
        shift_out_q <= {shift_out_q[6:0], 1'b0};
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupt pin and status outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      interrupt_output_pin_b_o  <= 1'b1;
      conversion_enable_o       <= 1'b0;
      result_available_signal_o <= 1'b0;
    end else begin
      conversion_enable_o       <= active;
      result_available_signal_o <= ready_q;
      unique case (pin_fn)
        PIN_FN_OFF:     interrupt_output_pin_b_o <= 1'b1;
        PIN_FN_WAKE:    interrupt_output_pin_b_o <= ~above_q;
        PIN_FN_COMPARE: interrupt_output_pin_b_o <= ~comp_q;
        PIN_FN_READY:   interrupt_output_pin_b_o <= ~ready_q;
        default:        interrupt_output_pin_b_o <= 1'b1;
      endcase
    end
  end

endmodule

// ==== testbench/sensor_regs_properties.sv ====
// Port-level timing checks for the sensor register bank
`timescale 1ns/1ps
module sensor_regs_properties (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic spi_clk_i,
  input wire logic spi_cs_b_i,
  input wire logic spi_miso_o,
  input wire logic spi_miso_oe_b_o,
  input wire logic conversion_enable_o,
  input wire logic result_available_signal_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);
  // ----------------------------------------------------------------
  // Serial output
  // ----------------------------------------------------------------
  property p_oe_on;
    !spi_cs_b_i [*8] |-> !spi_miso_oe_b_o;
  endproperty
  a_oe_on: assert property (p_oe_on) else $error("oe not low");
  property p_oe_off;
    spi_cs_b_i [*8] |-> spi_miso_oe_b_o;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("oe not high");
  property p_oe_fall;
    $fell(spi_miso_oe_b_o) |-> !$past(spi_cs_b_i, 3);
  endproperty
  a_oe_fall: assert property (p_oe_fall) else $error("early oe");
  property p_oe_rise;
    $rose(spi_miso_oe_b_o) |-> $past(spi_cs_b_i, 3);
  endproperty
  a_oe_rise: assert property (p_oe_rise) else $error("early off");
  property p_miso_hold;
    !spi_cs_b_i && $changed(spi_miso_o) |-> !spi_clk_i;
  endproperty
  a_miso_hold: assert property (p_miso_hold) else $error("miso moved");
  property p_miso_idle;
    spi_cs_b_i [*8] |-> $stable(spi_miso_o);
  endproperty
  a_miso_idle: assert property (p_miso_idle) else $error("idle miso");
  // ----------------------------------------------------------------
  // Conversion state
  // ----------------------------------------------------------------
  property p_en_write;
    $changed(conversion_enable_o) |-> !spi_cs_b_i;
  endproperty
  a_en_write: assert property (p_en_write) else $error("enable moved");
  property p_rdy_set;
    $rose(result_available_signal_o) |-> $past(conversion_enable_o);
  endproperty
  a_rdy_set: assert property (p_rdy_set) else $error("ready in standby");
  property p_rdy_clr;
    $fell(result_available_signal_o) |-> !spi_cs_b_i;
  endproperty
  a_rdy_clr: assert property (p_rdy_clr) else $error("ready lost");
endmodule
bind inductive_sensor_result_regs sensor_regs_properties u_props (
  .clock_i(clock_i),
  .rst_b_i(rst_b_i),
  .spi_clk_i(spi_clk_i),
  .spi_cs_b_i(spi_cs_b_i),
  .spi_miso_o(spi_miso_o),
  .spi_miso_oe_b_o(spi_miso_oe_b_o),
  .conversion_enable_o(conversion_enable_o),
  .result_available_signal_o(result_available_signal_o)
);

// ==== testbench/spi_host_model.sv ====
// Host controller model for the serial register port
`timescale 1ns/1ps
module spi_host_model (
  input  wire logic clock_i,
  input  wire logic spi_miso_i,
  output logic      spi_clk_o,
  output logic      spi_cs_b_o,
  output logic      spi_mosi_o
);
  localparam int HALF = 8;
  initial begin
    spi_clk_o = 1'b0;
    spi_cs_b_o = 1'b1;
    spi_mosi_o = 1'b0;
  end
  // One frame, mode 0, MSB first; clock idles low outside frames
  task automatic xfer(input logic [15:0] cmd, output logic [7:0] rd);
    rd = 8'h00;
    @(negedge clock_i) spi_cs_b_o = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      spi_mosi_o = cmd[i];
      repeat (HALF) @(negedge clock_i);
      spi_clk_o = 1'b1;
      if (i < 8) rd[i] = spi_miso_i;
      repeat (HALF) @(negedge clock_i);
      spi_clk_o = 1'b0;
    end
    repeat (HALF) @(negedge clock_i);
    spi_cs_b_o = 1'b1;
    spi_mosi_o = ~spi_mosi_o;
    repeat (HALF) @(negedge clock_i);
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] j;
    xfer({1'b0, a, d}, j);
  endtask
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    xfer({1'b1, a, 8'h00}, d);
  endtask
  // Status, then result low and high back to back
  task automatic rd_res(output logic [7:0] s, lo, hi);
    rd(7'h20, s);
    rd(7'h21, lo);
    rd(7'h22, hi);
  endtask
endmodule

// ==== testbench/tb.sv ====
// Self-checking bench for the sensor result register bank
`timescale 1ns/1ps
module tb;
  import sensor_regs_pkg::*;
  localparam logic [23:0] CNT = 24'h000200;
  localparam logic [23:0] CNT2 = 24'h000400;
  logic        clock_i, rst_b_i, sck, cs_b, mosi, osc, osc_run;
  logic [15:0] sample;
  logic        miso, oe_b, pin_b, conv_en, ready;
  logic [7:0]  v, s, lo, hi;
  logic [7:0]  hi_lsb, wd_set;
  logic [2:0]  win_code;
  logic [6:0]  ra [5];
  logic [7:0]  rv [5];
  int          n_errors, total_checks, cycles;
  // Released data line shows the inverse of the last bit
  spi_host_model h (.clock_i(clock_i), .spi_miso_i(oe_b ? ~miso : miso),
    .spi_clk_o(sck), .spi_cs_b_o(cs_b), .spi_mosi_o(mosi));
  inductive_sensor_result_regs uut (
    .clock_i(clock_i), .rst_b_i(rst_b_i), .spi_clk_i(sck),
    .spi_cs_b_i(cs_b), .spi_mosi_i(mosi), .sensor_osc_i(osc),
    .upper_threshold_low_byte_i(hi_lsb),
    .conversion_window_length_i(win_code),
    .min_sensor_freq_i(wd_set), .proximity_sample_i(sample),
    .spi_miso_o(miso), .spi_miso_oe_b_o(oe_b),
    .interrupt_output_pin_b_o(pin_b), .conversion_enable_o(conv_en),
    .result_available_signal_o(ready));
  initial begin
    clock_i = 1'b0;
    forever #10 clock_i = ~clock_i;
  end
  // Sensor square wave, period of 8 clocks
  always begin
    repeat (4) @(negedge clock_i);
    if (osc_run) osc = ~osc;
  end
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 60000) begin
      n_errors++;
      end_sim();
    end
  end
  task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wait_lvl(input logic l);
    for (int k = 0; k < 3000 && ready !== l; k++) @(negedge clock_i);
    chk("ready", {7'h00, l}, {7'h00, ready});
  endtask
  task automatic settle();
    repeat (600) @(negedge clock_i);
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    rst_b_i = 1'b0;
    osc = 1'b0;
    osc_run = 1'b1;
    sample = 16'h5000;
    hi_lsb = 8'h00;
    win_code = WIN_BASE_CODE;
    wd_set = 8'hF0;
    ra = '{ADDR_THR_HI_HIGH, ADDR_THR_LO_LOW, ADDR_THR_LO_HIGH,
      ADDR_INT_CFG, ADDR_PWR_CFG};
    rv = '{RST_THR_HI_HIGH, RST_THR_LO, RST_THR_LO, RST_INT_CFG, RST_PWR_CFG};
    repeat (10) @(negedge clock_i);
    rst_b_i = 1'b1;
    repeat (4) @(negedge clock_i);
    // ----------------------------------------------------------------
    // Reset values, readback, unmapped place
    // ----------------------------------------------------------------
    foreach (ra[i]) begin
      h.rd(ra[i], v);
      chk("reset value", rv[i], v);
    end
    chk("pin idle", 8'h01, {7'h00, pin_b});
    chk("oe idle", 8'h01, {7'h00, oe_b});
    foreach (ra[i]) begin
      if (i == 3) continue;
      h.wr(ra[i], 8'hA4);
      h.rd(ra[i], v);
      chk("readback", 8'hA4, v);
    end
    h.wr(7'h30, 8'h5A);
    h.rd(7'h30, v);
    chk("unmapped", 8'h00, v);
    // ----------------------------------------------------------------
    // Wake mode, result latch, period count
    // ----------------------------------------------------------------
    h.wr(ADDR_THR_HI_HIGH, 8'h40);
    h.wr(ADDR_THR_LO_LOW, 8'h00);
    h.wr(ADDR_THR_LO_HIGH, 8'h20);
    h.wr(ADDR_INT_CFG, {5'h00, PIN_FN_WAKE});
    h.wr(ADDR_PWR_CFG, 8'h01);
    chk("active", 8'h01, {7'h00, conv_en});
    wait_lvl(1'b1);
    chk("wake pin", 8'h00, {7'h00, pin_b});
    h.rd_res(s, lo, hi);
    chk("status", 8'h50, s);
    chk("result low", 8'h00, lo);
    chk("result high", 8'h50, hi);
    for (int i = 0; i < 3; i++) begin
      h.rd(ADDR_COUNT_LOW + 7'(i), v);
      chk("count", CNT[8*i +: 8], v);
    end
    // ----------------------------------------------------------------
    // Hold between thresholds, comparator mode, drop below lower
    // ----------------------------------------------------------------
    sample = 16'h3000;
    settle();
    h.rd(ADDR_PROX_HIGH, v);
    chk("unlatched high", 8'h50, v);
    chk("wake pin off", 8'h01, {7'h00, pin_b});
    h.rd_res(s, lo, hi);
    chk("status", 8'h70, s);
    chk("result high", 8'h30, hi);
    h.wr(ADDR_INT_CFG, {5'h00, PIN_FN_COMPARE});
    chk("comp pin", 8'h00, {7'h00, pin_b});
    sample = 16'h1000;
    settle();
    chk("comp pin off", 8'h01, {7'h00, pin_b});
    h.rd_res(s, lo, hi);
    chk("status", 8'h60, s);
    chk("result high", 8'h10, hi);
    // ----------------------------------------------------------------
    // Ready mode in standby, then pin off
    // ----------------------------------------------------------------
    settle();
    h.wr(ADDR_PWR_CFG, 8'h00);
    chk("standby", 8'h00, {7'h00, conv_en});
    h.wr(ADDR_INT_CFG, {5'h00, PIN_FN_READY});
    chk("ready pin", 8'h00, {7'h00, pin_b});
    h.rd(ADDR_PROX_LOW, v);
    chk("result low", 8'h00, v);
    chk("ready pin off", 8'h01, {7'h00, pin_b});
    repeat (1200) @(negedge clock_i);
    chk("no conversion", 8'h00, {7'h00, ready});
    h.wr(ADDR_INT_CFG, {5'h00, PIN_FN_OFF});
    h.wr(ADDR_PWR_CFG, 8'h01);
    wait_lvl(1'b1);
    chk("pin off", 8'h01, {7'h00, pin_b});
    // ----------------------------------------------------------------
    // Upper threshold low byte, longer window
    // ----------------------------------------------------------------
    h.wr(ADDR_INT_CFG, {5'h00, PIN_FN_WAKE});
    sample = 16'h4010;
    settle();
    chk("above upper", 8'h00, {7'h00, pin_b});
    hi_lsb = 8'h20;
    settle();
    chk("below upper", 8'h01, {7'h00, pin_b});
    win_code = 3'h3;
    repeat (2100) @(negedge clock_i);
    for (int i = 0; i < 3; i++) begin
      h.rd(ADDR_COUNT_LOW + 7'(i), v);
      chk("long count", CNT2[8*i +: 8], v);
    end
    // ----------------------------------------------------------------
    // Oscillation timeout
    // ----------------------------------------------------------------
    wd_set = 8'hC0;
    osc_run = 1'b0;
    repeat (1500) @(negedge clock_i);
    h.rd(ADDR_STATUS, v);
    chk("no timeout", 8'h00, v & 8'h80);
    wd_set = 8'hF0;
    h.rd(ADDR_STATUS, v);
    chk("timeout", 8'h80, v & 8'h80);
    osc_run = 1'b1;
    repeat (100) @(negedge clock_i);
    h.rd(ADDR_STATUS, v);
    chk("timeout gone", 8'h00, v & 8'h80);
    end_sim();
  end
endmodule
